//--- verilog/scal_pkg.sv
`default_nettype none
// =====================================================================
// Seek cylinder address logic: shared constants and types
// =====================================================================
package scal_pkg;

  // ===================================================================
  // Widths
  // ===================================================================
  localparam int TGT_W   = 9;
  localparam int PAR_W   = 10;
  localparam int ADDR_W  = 5;
  localparam int DATA_W  = 32;
  localparam int STRB_W  = 4;

  // ===================================================================
  // Timing
  // ===================================================================
  localparam int MCLK_PERIOD_NS = 100;
  localparam int LOAD_DELAY_NS  = 400;
  // Least time, so round up to whole cycles
  localparam int LOAD_DELAY_CYC = (LOAD_DELAY_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int DLY_W          = 3;
  localparam logic [DLY_W-1:0] DLY_LAST  = 3'(LOAD_DELAY_CYC - 1);
  localparam logic [DLY_W-1:0] DLY_ZERO  = 3'h0;
  localparam logic [DLY_W-1:0] DLY_STEP  = 3'h1;

  // ===================================================================
  // Pin vector layout, all pins pass one synchroniser
  // ===================================================================
  localparam int PIN_D     = 0;
  localparam int PIN_C     = 1;
  localparam int PIN_RAMP  = 2;
  localparam int PIN_RST_N = 3;
  localparam int PIN_USEL  = 4;
  localparam int PIN_STB   = 5;
  localparam int PIN_ADR   = 6;
  localparam int PIN_W     = PIN_ADR + TGT_W;

  // ===================================================================
  // Datapath constants
  // ===================================================================
  localparam logic [TGT_W-1:0] TGT_CLEAR   = 9'h000;
  localparam logic [TGT_W-1:0] RAMP_TGT    = 9'h008;
  localparam logic [PAR_W-1:0] PAR_PRESET  = 10'h1FF;
  localparam logic [PAR_W-1:0] PAR_STEP    = 10'h001;
  localparam logic [PAR_W-1:0] RAMP_CYL    = 10'h008;
  localparam logic [5:0]       BAD_TOP6    = 6'h33;

  // ===================================================================
  // Register map, byte addresses
  // ===================================================================
  localparam logic [ADDR_W-1:0] REG_CONFIG  = 5'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 5'h04;
  localparam logic [ADDR_W-1:0] REG_TARGET  = 5'h08;
  localparam logic [ADDR_W-1:0] REG_PRESENT = 5'h0C;
  localparam logic [ADDR_W-1:0] REG_DIFF    = 5'h10;
  localparam int CFG_DENSITY = 0;
  localparam int ST_ACCEPT   = 0;
  localparam int ST_BAD      = 1;
  localparam int ST_RAMP     = 2;
  localparam int ST_FWD      = 3;
  localparam int ST_BUSY     = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ===================================================================
  // Types
  // ===================================================================
  typedef enum logic [0:0] {LD_IDLE, LD_WAIT} scal_ld_t;

  // Bus slave state
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              arready;
    logic              aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_have;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } scal_axi_t;

  // Whole module state
  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] flt;
    scal_ld_t         ld;
    logic [DLY_W-1:0] dly;
    logic [TGT_W-1:0] target;
    logic [TGT_W-1:0] tgt_out;
    logic [PAR_W-1:0] present;
    logic [PAR_W-1:0] diff;
    logic             fwd;
    logic             ramp;
    logic             accepted;
    logic             bad;
    logic             density;
    scal_axi_t        axi;
  } scal_state_t;

endpackage
`default_nettype wire

//--- verilog/scal_top.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// Seek cylinder address logic
// =====================================================================
// Overview of operation
// - Target cylinder sits in nine flops fed through density selectors and gating.
// - Address lines reach the target only with unit selected and restore high.
// - At 200 tpi the address is stored straight, weight 1 in the lowest flop.
// - At 100 tpi the address shifts up one place and the lowest flop is set.
// - A valid address loads 400 ns after the synchronised strobe's leading edge is seen.
// - Restore low blocks the address gating and clears the target to zero.
// - Above 407 or 203 is invalid, decoded from six top address bits.
// - Each strobe answers with accepted for valid, interlock for invalid addresses.
// - An invalid address never loads, so the last valid target stays.
// - Ramp is ORed into the weight-8 target bit during head load or unload.
// - Ramp clears on reaching cylinder 8, then a seek to zero follows.
// - Present cylinder is a 10-bit up/down counter, low eight and top two.
// - The 512 bit meets a constant one in the adder against overshoot.
// - Count pulses and direction come from two phase signals, four tracks a cycle.
// - First phase leading means forward, lagging means reverse.
// - Every transition of one phase alone gives one count; both at once give none.
// - Counter is one's complement: forward decrements, reverse increments.
// - Restore low presets nine low counter bits to ones and stops counting.
// - Counter works the same in both densities.
// - Target plus counter gives the signed track difference for the seek.
module scal_top (
  input  wire logic                           MCLK,
  input  wire logic                           ARST_N,
  input  wire logic [scal_pkg::TGT_W-1:0]     CYL_ADDR,
  input  wire logic                           CYL_STROBE,
  input  wire logic                           UNIT_SELECTED,
  input  wire logic                           RESTORE_N,
  input  wire logic                           RAMP_START,
  input  wire logic                           PHASE_C,
  input  wire logic                           PHASE_D,
  output var  logic [scal_pkg::TGT_W-1:0]     TARGET_CYL,
  output var  logic [scal_pkg::PAR_W-1:0]     PRESENT_CYL,
  output var  logic [scal_pkg::PAR_W-1:0]     TRACK_DIFF,
  output var  logic                           SEEK_FORWARD,
  output var  logic                           RAMP_ACTIVE,
  output var  logic                           TARGET_ACCEPTED,
  output var  logic                           BAD_TARGET_INTERLOCK,
  input  wire logic [scal_pkg::ADDR_W-1:0]    S_AXI_AWADDR,
  input  wire logic                           S_AXI_AWVALID,
  output var  logic                           S_AXI_AWREADY,
  input  wire logic [scal_pkg::DATA_W-1:0]    S_AXI_WDATA,
  input  wire logic [scal_pkg::STRB_W-1:0]    S_AXI_WSTRB,
  input  wire logic                           S_AXI_WVALID,
  output var  logic                           S_AXI_WREADY,
  output var  logic [1:0]                     S_AXI_BRESP,
  output var  logic                           S_AXI_BVALID,
  input  wire logic                           S_AXI_BREADY,
  input  wire logic [scal_pkg::ADDR_W-1:0]    S_AXI_ARADDR,
  input  wire logic                           S_AXI_ARVALID,
  output var  logic                           S_AXI_ARREADY,
  output var  logic [scal_pkg::DATA_W-1:0]    S_AXI_RDATA,
  output var  logic [1:0]                     S_AXI_RRESP,
  output var  logic                           S_AXI_RVALID,
  input  wire logic                           S_AXI_RREADY
);
  import scal_pkg::*;

  // ===================================================================
  // Functions
  // ===================================================================

  // Glitch filter: a bit moves only when stages two and three agree
  function automatic logic [PIN_W-1:0] pin_filter(
    input logic [PIN_W-1:0] s2,
    input logic [PIN_W-1:0] s3,
    input logic [PIN_W-1:0] flt
  );
    pin_filter = (s2 & s3) | (flt & (s2 | s3));
  endfunction

  // Density routing of the gated address into the nine target stages
  function automatic logic [TGT_W-1:0] route_addr(
    input logic [TGT_W-1:0] adr,
    input logic             low_dens
  );
    if (low_dens) begin
      route_addr = {adr[TGT_W-2:0], 1'b1};
    end else begin
      route_addr = adr;
    end
  endfunction

  // Only the six top bits are looked at, so the limit is a multiple
  function automatic logic addr_invalid(
    input logic [TGT_W-1:0] adr,
    input logic             low_dens
  );
    if (low_dens) begin
      addr_invalid = adr[TGT_W-1] || (adr[TGT_W-2:2] >= BAD_TOP6);
    end else begin
      addr_invalid = adr[TGT_W-1:3] >= BAD_TOP6;
    end
  endfunction

  // Target plus one's complement present, end-around carry
  function automatic logic [PAR_W:0] track_sum(
    input logic [TGT_W-1:0] tgt,
    input logic [PAR_W-1:0] par
  );
    logic [PAR_W:0]   raw;
    logic [PAR_W-1:0] fold;
    raw  = {2'b01, tgt} + {1'b0, par};
    fold = raw[PAR_W-1:0] + {{(PAR_W-1){1'b0}}, raw[PAR_W]};
    track_sum = {raw[PAR_W], fold};
  endfunction

  // Read data for one aligned word
  function automatic logic [DATA_W+1:0] reg_read(
    input logic [ADDR_W-1:0] adr,
    input scal_state_t       st
  );
    logic [DATA_W-1:0] d;
    logic [1:0]        r;
    d = '0;
    r = RESP_OKAY;
    case (adr)
      REG_CONFIG: begin
        d[CFG_DENSITY] = st.density;
      end
      REG_STATUS: begin
        d[ST_ACCEPT] = st.accepted;
        d[ST_BAD]    = st.bad;
        d[ST_RAMP]   = st.ramp;
        d[ST_FWD]    = st.fwd;
        d[ST_BUSY]   = (st.ld == LD_WAIT);
      end
      REG_TARGET: begin
        d[TGT_W-1:0] = st.tgt_out;
      end
      REG_PRESENT: begin
        d[PAR_W-1:0] = st.present;
      end
      REG_DIFF: begin
        d[PAR_W-1:0] = st.diff;
      end
      default: begin
        r = RESP_SLVERR;
      end
    endcase
    reg_read = {r, d};
  endfunction

  // ===================================================================
  // State
  // ===================================================================
  scal_state_t      q_r;
  scal_state_t      q_nxt;
  logic [PIN_W-1:0] pins;

  // Every pin comes from outside the clock domain
  assign pins = {CYL_ADDR, CYL_STROBE, UNIT_SELECTED, RESTORE_N,
                 RAMP_START, PHASE_C, PHASE_D};

  // ===================================================================
  // Next state
  // ===================================================================
  always_comb begin
    logic [PIN_W-1:0]  fl;
    logic              stb_rise;
    logic              ramp_rise;
    logic              rst_n;
    logic              gate_en;
    logic [TGT_W-1:0]  gated;
    logic              c_n;
    logic              d_n;
    logic              c_chg;
    logic              d_chg;
    logic              fwd_move;
    logic [PAR_W:0]    sum;
    logic [DATA_W+1:0] rd;
    fl        = '0;
    stb_rise  = 1'b0;
    ramp_rise = 1'b0;
    rst_n     = 1'b0;
    gate_en   = 1'b0;
    gated     = '0;
    c_n       = 1'b0;
    d_n       = 1'b0;
    c_chg     = 1'b0;
    d_chg     = 1'b0;
    fwd_move  = 1'b0;
    sum       = '0;
    rd        = '0;
    q_nxt     = q_r;

    // Three stage synchroniser; stage one feeds only stage two
    q_nxt.s1  = pins;
    q_nxt.s2  = q_r.s1;
    q_nxt.s3  = q_r.s2;
    fl        = pin_filter(q_r.s2, q_r.s3, q_r.flt);
    q_nxt.flt = fl;

    stb_rise  = fl[PIN_STB] && !q_r.flt[PIN_STB];
    ramp_rise = fl[PIN_RAMP] && !q_r.flt[PIN_RAMP];
    rst_n     = fl[PIN_RST_N];

    // Input gating ahead of the selectors
    gate_en = fl[PIN_USEL] && rst_n;
    gated   = gate_en ? fl[PIN_ADR +: TGT_W] : TGT_CLEAR;

    // Load delay; a fresh strobe restarts it
    case (q_r.ld)
      LD_IDLE: begin
        if (stb_rise) begin
          q_nxt.ld  = LD_WAIT;
          q_nxt.dly = DLY_LAST;
        end
      end
      LD_WAIT: begin
        if (stb_rise) begin
          q_nxt.dly = DLY_LAST;
        end else if (q_r.dly != DLY_ZERO) begin
          q_nxt.dly = q_r.dly - DLY_STEP;
        end else begin
          q_nxt.ld = LD_IDLE;
          // Address must still be steady here, the pins are not latched
          if (addr_invalid(gated, q_r.density)) begin
            q_nxt.bad = 1'b1;
          end else begin
            q_nxt.target   = route_addr(gated, q_r.density);
            q_nxt.accepted = 1'b1;
          end
        end
      end
      default: begin
        q_nxt.ld = LD_IDLE;
      end
    endcase

    // Answers of the previous strobe drop at the next one
    if (stb_rise) begin
      q_nxt.accepted = 1'b0;
      q_nxt.bad      = 1'b0;
    end

    // Restore wins over any load in the same cycle
    if (!rst_n) begin
      q_nxt.target = TGT_CLEAR;
    end

    // Quadrature decode, C leading D means forward
    c_n      = fl[PIN_C];
    d_n      = fl[PIN_D];
    c_chg    = c_n ^ q_r.flt[PIN_C];
    d_chg    = d_n ^ q_r.flt[PIN_D];
    fwd_move = c_chg ? (c_n ^ d_n) : !(c_n ^ d_n);

    // Same counter for both densities; double step is ignored
    if (!rst_n) begin
      q_nxt.present = PAR_PRESET;
    end else if (c_chg ^ d_chg) begin
      if (fwd_move) begin
        q_nxt.present = q_r.present - PAR_STEP;
      end else begin
        q_nxt.present = q_r.present + PAR_STEP;
      end
    end

    // Ramp ends at cylinder 8; a new start wins over the end
    if (ramp_rise) begin
      q_nxt.ramp = 1'b1;
    end else if (q_r.ramp && (~q_r.present[TGT_W-1:0] == RAMP_CYL[TGT_W-1:0])) begin
      q_nxt.ramp = 1'b0;
    end

    // Target seen by the adder, ramp forced into weight 8
    q_nxt.tgt_out = q_nxt.target | (q_nxt.ramp ? RAMP_TGT : TGT_CLEAR);
    sum           = track_sum(q_nxt.tgt_out, q_nxt.present);
    q_nxt.fwd     = sum[PAR_W];
    q_nxt.diff    = sum[PAR_W-1:0];

    // ================================================================
    // AXI4-Lite write side, address and data in either order
    // ================================================================
    if (S_AXI_AWVALID && q_r.axi.awready) begin
      q_nxt.axi.aw_have = 1'b1;
      q_nxt.axi.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && q_r.axi.wready) begin
      q_nxt.axi.w_have = 1'b1;
      q_nxt.axi.w_data = S_AXI_WDATA;
      q_nxt.axi.w_strb = S_AXI_WSTRB;
    end
    if (q_r.axi.bvalid && S_AXI_BREADY) begin
      q_nxt.axi.bvalid = 1'b0;
    end
    if (q_nxt.axi.aw_have && q_nxt.axi.w_have && !q_nxt.axi.bvalid) begin
      q_nxt.axi.aw_have = 1'b0;
      q_nxt.axi.w_have  = 1'b0;
      q_nxt.axi.bvalid  = 1'b1;
      if (q_nxt.axi.aw_addr == REG_CONFIG) begin
        q_nxt.axi.bresp = RESP_OKAY;
        if (q_nxt.axi.w_strb[0]) begin
          q_nxt.density = q_nxt.axi.w_data[CFG_DENSITY];
        end
      end else begin
        // Read-only or unmapped word
        q_nxt.axi.bresp = RESP_SLVERR;
      end
    end
    q_nxt.axi.awready = !q_nxt.axi.aw_have && !q_nxt.axi.bvalid;
    q_nxt.axi.wready  = !q_nxt.axi.w_have && !q_nxt.axi.bvalid;

    // ================================================================
    // AXI4-Lite read side, one read under way at a time
    // ================================================================
    if (q_r.axi.rvalid && S_AXI_RREADY) begin
      q_nxt.axi.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && q_r.axi.arready) begin
      rd               = reg_read(S_AXI_ARADDR, q_r);
      q_nxt.axi.rvalid = 1'b1;
      q_nxt.axi.rdata  = rd[DATA_W-1:0];
      q_nxt.axi.rresp  = rd[DATA_W+1:DATA_W];
    end
    q_nxt.axi.arready = !q_nxt.axi.rvalid;
  end

  // ===================================================================
  // Registers
  // ===================================================================
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ===================================================================
  // Outputs, all straight from flops
  // ===================================================================
  assign TARGET_CYL           = q_r.tgt_out;
  assign PRESENT_CYL          = q_r.present;
  assign TRACK_DIFF           = q_r.diff;
  assign SEEK_FORWARD         = q_r.fwd;
  assign RAMP_ACTIVE          = q_r.ramp;
  assign TARGET_ACCEPTED      = q_r.accepted;
  assign BAD_TARGET_INTERLOCK = q_r.bad;
  assign S_AXI_AWREADY        = q_r.axi.awready;
  assign S_AXI_WREADY         = q_r.axi.wready;
  assign S_AXI_BRESP          = q_r.axi.bresp;
  assign S_AXI_BVALID         = q_r.axi.bvalid;
  assign S_AXI_ARREADY        = q_r.axi.arready;
  assign S_AXI_RDATA          = q_r.axi.rdata;
  assign S_AXI_RRESP          = q_r.axi.rresp;
  assign S_AXI_RVALID         = q_r.axi.rvalid;

endmodule
`default_nettype wire

//--- dv/scal_props.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// Port checker for the seek cylinder block
// =====================================================================
module scal_props (
  input wire logic                       MCLK,
  input wire logic                       ARST_N,
  input wire logic                       CYL_STROBE,
  input wire logic                       RESTORE_N,
  input wire logic [scal_pkg::TGT_W-1:0] TARGET_CYL,
  input wire logic [scal_pkg::PAR_W-1:0] PRESENT_CYL,
  input wire logic [scal_pkg::PAR_W-1:0] TRACK_DIFF,
  input wire logic                       SEEK_FORWARD,
  input wire logic                       RAMP_ACTIVE,
  input wire logic                       TARGET_ACCEPTED,
  input wire logic                       BAD_TARGET_INTERLOCK
);
  import scal_pkg::*;
  logic [10:0] sum_w;
  // Fixed one in the 512 bit keeps an overshoot from reading as a huge error
  assign sum_w = {2'h1, TARGET_CYL} + {1'h0, PRESENT_CYL};
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  property p_clear; !RESTORE_N [*7] |-> (TARGET_CYL & ~RAMP_TGT) == TGT_CLEAR; endproperty
  a_clear: assert property (p_clear) else $error("target not cleared by restore");
  property p_preset; !RESTORE_N [*7] |-> PRESENT_CYL == PAR_PRESET; endproperty
  a_preset: assert property (p_preset) else $error("counter not preset");
  property p_ramp_or; RAMP_ACTIVE && $past(RAMP_ACTIVE) |-> TARGET_CYL[3]; endproperty
  a_ramp_or: assert property (p_ramp_or) else $error("ramp not in target");
  property p_ramp_end; RAMP_ACTIVE && (~PRESENT_CYL[8:0]) == 9'h008 |=> !RAMP_ACTIVE; endproperty
  a_ramp_end: assert property (p_ramp_end) else $error("ramp kept past cylinder 8");
  // Flags drop once the synced edge is seen, answer lands four cycles on
  property p_load;
    $rose(CYL_STROBE) && RESTORE_N |-> ##5 !(TARGET_ACCEPTED || BAD_TARGET_INTERLOCK)
      ##4 (TARGET_ACCEPTED || BAD_TARGET_INTERLOCK);
  endproperty
  a_load: assert property (p_load) else $error("strobe answer mistimed");
  property p_excl; !(TARGET_ACCEPTED && BAD_TARGET_INTERLOCK); endproperty
  a_excl: assert property (p_excl) else $error("accept and interlock together");
  property p_keep; $rose(BAD_TARGET_INTERLOCK) |-> $stable(TARGET_CYL); endproperty
  a_keep: assert property (p_keep) else $error("invalid address loaded");
  property p_count;
    RESTORE_N && $past(RESTORE_N, 7) && PRESENT_CYL != $past(PRESENT_CYL)
      |-> 10'(PRESENT_CYL - $past(PRESENT_CYL)) inside {10'h001, 10'h3FF};
  endproperty
  a_count: assert property (p_count) else $error("counter moved by more than one");
  property p_diff;
    $stable(TARGET_CYL) && $stable(PRESENT_CYL) && $past(ARST_N, 2)
      |-> TRACK_DIFF == sum_w[9:0] + 10'(sum_w[10]) && SEEK_FORWARD == sum_w[10];
  endproperty
  a_diff: assert property (p_diff) else $error("track difference wrong");
endmodule
`default_nettype wire

//--- dv/scal_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// Controller side: puts a cylinder on the lines, then strobes
// =====================================================================
module scal_ctrl_model (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       go,
  input  wire logic [scal_pkg::TGT_W-1:0] addr_in,
  output var  logic [scal_pkg::TGT_W-1:0] cyl_addr,
  output var  logic                       cyl_strobe
);
  import scal_pkg::*;
  logic [4:0] cnt_r;
  // Address leads the strobe by a cycle and outlives the load window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r      <= 5'h00;
      cyl_addr   <= '0;
      cyl_strobe <= 1'b0;
    end else if (go && cnt_r == 5'h00) begin
      cnt_r    <= 5'h10;
      cyl_addr <= addr_in;
    end else if (cnt_r != 5'h00) begin
      cnt_r      <= cnt_r - 5'h01;
      cyl_strobe <= (cnt_r > 5'h0C); // Four cycles high, past the filter
      // Released lines show the inverse, so a stale value cannot pass
      if (cnt_r == 5'h01) cyl_addr <= ~cyl_addr;
    end
  end
endmodule
`default_nettype wire

//--- dv/scal_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// Bench for the seek cylinder block
// =====================================================================
module scal_top_tb;
  import scal_pkg::*;
  typedef struct packed {logic bad; logic [TGT_W-1:0] tgt;} scal_exp_t;
  localparam logic [TGT_W-1:0] BND [6] = '{9'h197, 9'h198, 9'h0CB, 9'h0CC, 9'h1FF, 9'h000};
  logic              mclk = 1'b0, arst_n = 1'b0, usel = 1'b1, rst_pin = 1'b0, ramp_pin = 1'b0;
  logic              ph_c = 1'b0, ph_d = 1'b0, go = 1'b0, dens = 1'b0, acc_q, bad_q;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, cyl_stb, acc, bad, fwd, ramp;
  logic [TGT_W-1:0]  go_addr = '0, cyl_addr, tgt, cur_tgt = '0;
  logic [PAR_W-1:0]  pres, diff, exp_par;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, rv, seed = 32'h81AF578E;
  logic [STRB_W-1:0] wstrb = '0;
  logic [1:0]        bresp, rresp, rr, ph = 2'h0;
  int                failures = 0, samples_checked = 0, cyc = 0;
  scal_exp_t         q [$];
  scal_exp_t         me;

  scal_top DUT (.MCLK(mclk), .ARST_N(arst_n), .CYL_ADDR(cyl_addr), .CYL_STROBE(cyl_stb),
    .UNIT_SELECTED(usel), .RESTORE_N(rst_pin), .RAMP_START(ramp_pin), .PHASE_C(ph_c),
    .PHASE_D(ph_d), .TARGET_CYL(tgt), .PRESENT_CYL(pres), .TRACK_DIFF(diff),
    .SEEK_FORWARD(fwd), .RAMP_ACTIVE(ramp), .TARGET_ACCEPTED(acc), .BAD_TARGET_INTERLOCK(bad),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  scal_ctrl_model u_ctrl (.clk(mclk), .rst_n(arst_n), .go(go), .addr_in(go_addr),
    .cyl_addr(cyl_addr), .cyl_strobe(cyl_stb));

  // =====================================================================
  // Helpers
  // =====================================================================
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Each channel drops valid only at its own handshake edge
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("bresp", 32'(bresp), 32'(er));
  endtask
  task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  // Note the outcome, then let the controller model strobe it in
  task automatic strobe(input logic [TGT_W-1:0] a, input logic sel);
    logic [TGT_W-1:0] g;
    logic             ok;
    @(posedge mclk);
    usel <= sel; go <= 1'b1; go_addr <= a;
    g = sel ? a : 9'h000;
    ok = dens ? (g <= 9'h0CB) : (g <= 9'h197);
    if (ok) cur_tgt = dens ? {g[7:0], 1'b1} : g;
    q.push_back('{bad: !ok, tgt: cur_tgt});
    @(posedge mclk);
    go <= 1'b0;
    repeat (18) @(posedge mclk);
  endtask
  // Gray steps, C leading D when forward; four cycles keep the filter happy
  task automatic step(input logic fw, input int n, input logic counts);
    repeat (n) begin
      @(posedge mclk);
      ph = fw ? ph + 2'h1 : ph - 2'h1;
      ph_c <= ph[1] ^ ph[0]; ph_d <= ph[1];
      if (counts) exp_par = fw ? exp_par - 10'h001 : exp_par + 10'h001;
      repeat (3) @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
    check("present", 32'(pres), 32'(exp_par));
  endtask

  // =====================================================================
  // Clock, timeout and result watcher
  // =====================================================================
  initial forever #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end
  // A fresh flag consumes the oldest note
  always @(posedge mclk) begin
    if ((acc === 1'b1 && !acc_q) || (bad === 1'b1 && !bad_q)) begin
      if (q.size() == 0) check("unexpected flag", 32'h1, 32'h0);
      else begin
        me = q.pop_front();
        check("interlock", 32'(bad), 32'(me.bad));
        check("target", 32'(tgt), 32'(me.tgt));
      end
    end
    acc_q = (acc === 1'b1);
    bad_q = (bad === 1'b1);
  end

  // =====================================================================
  // Main sequence
  // =====================================================================
  initial begin
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    check("preset", 32'(pres), 32'(PAR_PRESET));
    check("cleared", 32'(tgt), 32'(TGT_CLEAR));
    rst_pin <= 1'b1;
    repeat (8) @(posedge mclk);
    exp_par = PAR_PRESET;
    axi_rd(5'h14, rv, rr);
    check("rresp", 32'(rr), 32'(RESP_SLVERR));
    axi_wr(5'h1C, 32'h1, RESP_SLVERR);
    for (int k = 0; k < 2; k++) begin
      dens = k[0];
      axi_wr(REG_CONFIG, 32'(dens), RESP_OKAY);
      axi_rd(REG_CONFIG, rv, rr);
      check("config", rv, 32'(dens));
      foreach (BND[i]) strobe(BND[i], 1'b1);
      strobe(9'h0AA, 1'b0);
      repeat (4) begin
        seed = xs(seed);
        strobe(seed[8:0], seed[9]);
      end
      axi_rd(REG_TARGET, rv, rr);
      check("target reg", rv, 32'(cur_tgt));
      repeat (3) begin
        seed = xs(seed);
        step(seed[0], 5 + int'(seed[3:1]), 1'b1);
      end
      axi_rd(REG_PRESENT, rv, rr);
      check("present reg", rv, 32'(exp_par));
    end
    // Restore mid-run: phases must not count while it is low
    rst_pin <= 1'b0;
    cur_tgt = TGT_CLEAR;
    exp_par = PAR_PRESET;
    repeat (6) @(posedge mclk);
    step(1'b1, 3, 1'b0);
    check("restore target", 32'(tgt), 32'(TGT_CLEAR));
    rst_pin <= 1'b1;
    repeat (8) @(posedge mclk);
    // Head load ramp out to cylinder 8, then check the seek back to zero is set up
    ramp_pin <= 1'b1;
    repeat (8) @(posedge mclk);
    check("ramp target", 32'(tgt), 32'(RAMP_TGT));
    ramp_pin <= 1'b0;
    step(1'b1, 8, 1'b1);
    check("ramp", 32'(ramp), 32'h0);
    check("seek dir", 32'(fwd), 32'h0);
    check("diff", 32'(diff), 32'h3F7);
    wrap_up();
  end
endmodule

bind scal_top scal_props u_props (.MCLK(MCLK), .ARST_N(ARST_N), .CYL_STROBE(CYL_STROBE),
  .RESTORE_N(RESTORE_N), .TARGET_CYL(TARGET_CYL), .PRESENT_CYL(PRESENT_CYL),
  .TRACK_DIFF(TRACK_DIFF), .SEEK_FORWARD(SEEK_FORWARD), .RAMP_ACTIVE(RAMP_ACTIVE),
  .TARGET_ACCEPTED(TARGET_ACCEPTED), .BAD_TARGET_INTERLOCK(BAD_TARGET_INTERLOCK));
`default_nettype wire
